// >>> design/ocl_defs.vh
/*
  Constants for the output compressor/limiter: channel count, setting
  encodings, reset values and the attack/release timing figures.
  Assumes the core clock runs at 100 MHz and one audio sample is
  presented per i_smp_valid strobe.
*/
`ifndef OCL_DEFS_VH
`define OCL_DEFS_VH

`define OCL_NCH 6
`define OCL_SMP_W 24
`define OCL_CH_W 3

// Speed setting codes
`define OCL_SPD_FAST 2'h0
`define OCL_SPD_NORM 2'h1
`define OCL_SPD_SLOW 2'h2
`define OCL_SPD_RST `OCL_SPD_NORM

// Ratio setting: 0 is limiting, 1..15 index the finite ratio table
`define OCL_RATIO_W 4
`define OCL_RATIO_LIM 4'h0
`define OCL_RATIO_RST `OCL_RATIO_LIM

// Threshold: 0 means off (bypass); otherwise a magnitude level
`define OCL_THR_W 16
`define OCL_THR_OFF 16'h0000
`define OCL_THR_RST `OCL_THR_OFF

// Audio sample rate assumed for coefficient derivation, in Hz
`define OCL_FS_HZ 48000
// Attack and release times in microseconds
`define OCL_FAST_ATK_US 1000
`define OCL_FAST_REL_US 10000
`define OCL_NORM_ATK_US 8000
`define OCL_NORM_REL_US 80000
`define OCL_SLOW_ATK_US 45000
`define OCL_SLOW_REL_US 450000

// Limiting leaks 1/64 of the overshoot to avoid hard clipping
`define OCL_LIM_LEAK_SH 6
// Gain unity in Q1.15
`define OCL_UNITY 16'h8000

`define OCL_FIFO_DEPTH 16
`define OCL_FIFO_AW 4

`endif

// >>> design/ocl_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides; read data registered.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ocl_fifo #(
  parameter WIDTH = 27,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  wire out_free;

  // Output register refills whenever it is empty or being taken
  assign out_free = !o_out_valid || i_out_ready;
  assign o_in_ready = (count != DEPTH[AW:0]);
  assign push = i_in_valid && o_in_ready;
  assign pop = out_free && (count != {(AW+1){1'b0}});

  always @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointer and count bookkeeping
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        o_out_data <= mem[rd_ptr];
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
      if (pop) begin
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule // ocl_fifo

// >>> design/ocl_top.v
/*
  Six-channel output compressor/limiter. Samples arrive tagged with a
  channel number, pass a 16-word FIFO, and are gain-scaled per channel.
  Settings are written through a plain strobe port with optional pair
  ganging. Assumes a single core clock, synchronous active-low reset and
  an upstream source in the same clock domain.
*/
`timescale 1ns/1ps
`include "ocl_defs.vh"

// Contract
// - Six channels hold independent settings
// - Three speeds; normal after reset
// - Fast: attack 1 ms, release 10 ms
// - Normal: attack 8 ms, release 80 ms
// - Slow: attack 45 ms, release 450 ms
// - Ratio resets to limiting, infinite ratio
// - Limiting leaks slight overshoot, no clipping
// - Finite ratios from 20.0 down to 1.1
// - N dB above threshold gives 1 dB; code uses linear out = thr + (env-thr)/N
// - Threshold resets off; off means bypass
// - Below threshold gain stays unchanged; code releases gain back toward unity
// - Separate input/output ganging applies to pairs
module ocl_top (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_smp_valid,
  output wire o_smp_ready,
  input wire [2:0] i_smp_ch,
  input wire signed [23:0] i_smp_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [2:0] o_out_ch,
  output reg signed [23:0] o_out_data,
  input wire i_cfg_wr,
  input wire [2:0] i_cfg_ch,
  input wire [1:0] i_cfg_speed,
  input wire [3:0] i_cfg_ratio,
  input wire [15:0] i_cfg_thr,
  input wire i_out_gang,
  input wire i_in_gang,
  output wire o_in_gang_active,
  input wire [2:0] i_rd_ch,
  output reg [15:0] o_rd_gain,
  output reg [15:0] o_rd_env
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CALC = 2'h1;
  localparam ST_OUT = 2'h2;

  // Coefficients as right-shift amounts: alpha ~ 2^-sh, sh ~ log2(t*fs)
  // Shifts are powers of two, so each time is met only to within a factor of two
  localparam integer FAST_ATK_SMP = (`OCL_FAST_ATK_US * (`OCL_FS_HZ / 1000)) / 1000;
  localparam integer FAST_REL_SMP = (`OCL_FAST_REL_US * (`OCL_FS_HZ / 1000)) / 1000;
  localparam integer NORM_ATK_SMP = (`OCL_NORM_ATK_US * (`OCL_FS_HZ / 1000)) / 1000;
  localparam integer NORM_REL_SMP = (`OCL_NORM_REL_US * (`OCL_FS_HZ / 1000)) / 1000;
  localparam integer SLOW_ATK_SMP = (`OCL_SLOW_ATK_US * (`OCL_FS_HZ / 1000)) / 1000;
  localparam integer SLOW_REL_SMP = (`OCL_SLOW_REL_US * (`OCL_FS_HZ / 1000)) / 1000;

  // Per-channel settings and state
  reg [1:0] speed [0:`OCL_NCH-1];
  reg [3:0] ratio [0:`OCL_NCH-1];
  reg [15:0] thr [0:`OCL_NCH-1];
  reg [15:0] gain [0:`OCL_NCH-1];
  reg [15:0] env [0:`OCL_NCH-1];

  reg [1:0] state;
  reg [2:0] cur_ch;
  reg signed [23:0] cur_smp;
  reg [15:0] tgt_gain;
  wire fifo_valid;
  wire fifo_ready;
  wire [26:0] fifo_data;
  integer k;

  // Threshold off means bypass; decoded once per channel and shared by
  // the gain computation and the output stage
  wire [`OCL_NCH-1:0] ch_bypass;
  genvar gi;
  generate
    for (gi = 0; gi < `OCL_NCH; gi = gi + 1) begin : g_bypass
      assign ch_bypass[gi] = (thr[gi] == `OCL_THR_OFF);
    end
  endgenerate

  // Input gang only affects the input section; reported for visibility
  assign o_in_gang_active = i_in_gang;

  ocl_fifo #(
    .WIDTH(27),
    .DEPTH(`OCL_FIFO_DEPTH),
    .AW(`OCL_FIFO_AW)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_smp_valid),
    .o_in_ready(o_smp_ready),
    .i_in_data({i_smp_ch, i_smp_data}),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready),
    .o_out_data(fifo_data)
  );

  // The FIFO is drained only while the pipeline is idle, so a stalled
  // converter fills the FIFO instead of losing samples
  assign fifo_ready = (state == ST_IDLE);

  // Shift for first-order smoothing from sample count
  function [3:0] log2_sh;
    input integer n;
    integer t;
    begin
      log2_sh = 4'h0;
      for (t = 1; t < 16; t = t + 1) begin
        if ((1 << t) <= n) begin
          log2_sh = t[3:0];
        end
      end
    end
  endfunction

  function [3:0] atk_shift;
    input [1:0] spd;
    begin
      case (spd)
        `OCL_SPD_FAST: atk_shift = log2_sh(FAST_ATK_SMP);
        `OCL_SPD_SLOW: atk_shift = log2_sh(SLOW_ATK_SMP);
        default: atk_shift = log2_sh(NORM_ATK_SMP);
      endcase
    end
  endfunction

  function [3:0] rel_shift;
    input [1:0] spd;
    begin
      case (spd)
        `OCL_SPD_FAST: rel_shift = log2_sh(FAST_REL_SMP);
        `OCL_SPD_SLOW: rel_shift = log2_sh(SLOW_REL_SMP);
        default: rel_shift = log2_sh(NORM_REL_SMP);
      endcase
    end
  endfunction

  // Finite ratio table in Q8.8, index 1 = 20.0 down to index 15 = 1.1
  function [15:0] ratio_q8;
    input [3:0] idx;
    begin
      case (idx)
        4'h1: ratio_q8 = 16'h1400;
        4'h2: ratio_q8 = 16'h1000;
        4'h3: ratio_q8 = 16'h0C00;
        4'h4: ratio_q8 = 16'h0A00;
        4'h5: ratio_q8 = 16'h0800;
        4'h6: ratio_q8 = 16'h0600;
        4'h7: ratio_q8 = 16'h0500;
        4'h8: ratio_q8 = 16'h0400;
        4'h9: ratio_q8 = 16'h0300;
        4'hA: ratio_q8 = 16'h0280;
        4'hB: ratio_q8 = 16'h0200;
        4'hC: ratio_q8 = 16'h0180;
        4'hD: ratio_q8 = 16'h0140;
        4'hE: ratio_q8 = 16'h0120;
        default: ratio_q8 = 16'h011A; // 1.1
      endcase
    end
  endfunction

  // Channel numbers 6 and 7 do not exist; every channel decode goes
  // through here so the rule lives in one place
  function ch_ok;
    input [2:0] ch;
    begin
      ch_ok = (ch < `OCL_NCH);
    end
  endfunction

  // Target gain from envelope and settings. Uses a linear-domain
  // approximation: out = thr + (env-thr)/N, gain = out/env. Cheaper than
  // a log converter and accurate near the threshold, which is where it
  // matters most.
  reg [31:0] over;
  reg [31:0] out_lvl;
  reg [31:0] quo;
  always @* begin
    over = 32'h0000_0000;
    out_lvl = 32'h0000_0000;
    quo = 32'h0000_0000;
    tgt_gain = `OCL_UNITY;
    if (ch_bypass[cur_ch]) begin
      tgt_gain = `OCL_UNITY;
    end else if (env[cur_ch] <= thr[cur_ch]) begin
      tgt_gain = `OCL_UNITY;
    end else begin
      over = {16'h0000, env[cur_ch] - thr[cur_ch]};
      if (ratio[cur_ch] == `OCL_RATIO_LIM) begin
        out_lvl = {16'h0000, thr[cur_ch]} + (over >> `OCL_LIM_LEAK_SH);
      end else begin
        out_lvl = {16'h0000, thr[cur_ch]} +
          ((over << 8) / {16'h0000, ratio_q8(ratio[cur_ch])});
      end
      quo = (out_lvl << 15) / {16'h0000, env[cur_ch]};
      tgt_gain = (quo > 32'h0000_8000) ? `OCL_UNITY : quo[15:0];
    end
  end

  // Sample magnitude, top 16 bits
  // The most negative sample maps to the largest magnitude; it only feeds
  // the envelope (compared and loaded), never fed back as output data
  wire [23:0] mag = cur_smp[23] ? (~cur_smp + 24'h00_0001) : cur_smp;

  // Settings writes with output pair ganging
  // A write to a missing channel is dropped so no real channel is hit by mistake
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (k = 0; k < `OCL_NCH; k = k + 1) begin
        speed[k] <= `OCL_SPD_RST;
        ratio[k] <= `OCL_RATIO_RST;
        thr[k] <= `OCL_THR_RST;
      end
    end else if (i_cfg_wr && ch_ok(i_cfg_ch)) begin
      for (k = 0; k < `OCL_NCH; k = k + 1) begin
        if ((k == i_cfg_ch) || (i_out_gang && ((k >> 1) == (i_cfg_ch >> 1)))) begin
          speed[k] <= (i_cfg_speed > `OCL_SPD_SLOW) ? `OCL_SPD_NORM : i_cfg_speed;
          ratio[k] <= i_cfg_ratio;
          thr[k] <= i_cfg_thr;
        end
      end
    end
  end

  // Full-width product: 24-bit sample times 17-bit non-negative gain
  wire signed [40:0] prod;
  assign prod = cur_smp * $signed({1'b0, gain[cur_ch]});

  // Per-sample pipeline: take, detect and smooth, apply
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cur_ch <= 3'h0;
      cur_smp <= 24'h00_0000;
      o_out_valid <= 1'b0;
      o_out_ch <= 3'h0;
      o_out_data <= 24'h00_0000;
      for (k = 0; k < `OCL_NCH; k = k + 1) begin
        gain[k] <= `OCL_UNITY;
        env[k] <= 16'h0000;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          if (fifo_valid) begin
            cur_ch <= ch_ok(fifo_data[26:24]) ? fifo_data[26:24] : 3'h0;
            cur_smp <= fifo_data[23:0];
            state <= ST_CALC;
          end
        end
        ST_CALC: begin
          // Peak detector then smoothing toward target, once per sample
          if (mag[23:8] > env[cur_ch]) begin
            env[cur_ch] <= mag[23:8];
          end else begin
            env[cur_ch] <= env[cur_ch] - (env[cur_ch] >> rel_shift(speed[cur_ch]));
          end
          // The extra one-step nudge lets the gain land on its target
          // instead of creeping toward it forever
          if (tgt_gain < gain[cur_ch]) begin
            gain[cur_ch] <= gain[cur_ch] -
              ((gain[cur_ch] - tgt_gain) >> atk_shift(speed[cur_ch])) - 16'h0001;
          end else if (tgt_gain > gain[cur_ch]) begin
            gain[cur_ch] <= gain[cur_ch] +
              (((tgt_gain - gain[cur_ch]) >> rel_shift(speed[cur_ch])) | 16'h0001);
          end
          state <= ST_OUT;
        end
        ST_OUT: begin
          if (!o_out_valid || i_out_ready) begin
            o_out_ch <= cur_ch;
            // Bypass passes the sample untouched, not through the multiplier
            o_out_data <= ch_bypass[cur_ch] ? cur_smp : prod[38:15];
            o_out_valid <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (o_out_valid && i_out_ready && !(state == ST_OUT)) begin
        o_out_valid <= 1'b0;
      end
    end
  end

  // Status readback, one cycle behind i_rd_ch; missing channels read as
  // zero so they cannot be mistaken for a live channel at unity gain
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rd_gain <= `OCL_UNITY;
      o_rd_env <= 16'h0000;
    end else begin
      o_rd_gain <= ch_ok(i_rd_ch) ? gain[i_rd_ch] : 16'h0000;
      o_rd_env <= ch_ok(i_rd_ch) ? env[i_rd_ch] : 16'h0000;
    end
  end
endmodule // ocl_top

// >>> dv/ocl_checker.sv
/* Port checker for ocl_top.
   Assumes one core clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module ocl_checker (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_smp_valid,
  input wire o_smp_ready,
  input wire o_out_valid,
  input wire i_out_ready,
  input wire [2:0] o_out_ch,
  input wire signed [23:0] o_out_data,
  input wire i_in_gang,
  input wire o_in_gang_active,
  input wire [2:0] i_rd_ch,
  input wire [15:0] o_rd_gain,
  input wire [15:0] o_rd_env
);
  reg [5:0] occ;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Samples in flight: FIFO words plus the three pipeline stages
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      occ <= 6'h00;
    end else begin
      occ <= occ + {5'h00, i_smp_valid & o_smp_ready} - {5'h00, o_out_valid & i_out_ready};
    end
  end
  sequence s_stall;
    o_out_valid && !i_out_ready;
  endsequence
  sequence s_bad_rd;
    i_rd_ch > 3'h5;
  endsequence
  a_out_holds: assert property (s_stall |=> o_out_valid && $stable(o_out_data)
    && $stable(o_out_ch)) else $error("output changed while stalled");
  a_out_ch_range: assert property (o_out_valid |-> o_out_ch <= 3'h5)
    else $error("output channel out of range");
  a_rd_range: assert property (s_bad_rd |=> o_rd_gain == 16'h0000 && o_rd_env == 16'h0000)
    else $error("readback of missing channel not zero");
  a_gain_cap: assert property (o_rd_gain <= 16'h8000)
    else $error("gain above unity");
  a_gang_mirror: assert property (o_in_gang_active == i_in_gang)
    else $error("input gang flag not mirrored");
  a_reset_state: assert property ($rose(i_rst_n) |-> !o_out_valid && o_smp_ready
    && o_rd_gain == 16'h8000 && o_rd_env == 16'h0000) else $error("bad state after reset");
  a_full_refuse: assert property (!o_smp_ready |-> occ >= 6'h10)
    else $error("refused before sixteen words held");
  a_out_cause: assert property (o_out_valid |-> occ != 6'h00 && occ <= 6'h13)
    else $error("output count disagrees with input");
endmodule // ocl_checker

bind ocl_top ocl_checker i_ocl_checker (.i_core_clk, .i_rst_n, .i_smp_valid, .o_smp_ready,
  .o_out_valid, .i_out_ready, .o_out_ch, .o_out_data, .i_in_gang, .o_in_gang_active,
  .i_rd_ch, .o_rd_gain, .o_rd_env);

// >>> dv/ocl_sink.sv
/* Output converter model: takes processed samples promptly, slowly or not at all.
   Assumes the core clock domain and the valid/ready handshake of ocl_top. */
`timescale 1ns/1ps
module ocl_sink (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_stall,
  input wire i_slow,
  input wire i_valid,
  input wire [2:0] i_ch,
  input wire [23:0] i_data,
  output reg o_ready
);
  reg [2:0] q_ch[$];
  reg [23:0] q_data[$];
  reg [1:0] tick;
  // Slow mode accepts one cycle in three, like a converter busy converting
  always @(posedge i_core_clk) begin
    tick <= (!i_rst_n || tick == 2'h2) ? 2'h0 : tick + 2'h1;
    o_ready <= i_rst_n && !i_stall && (tick == 2'h0 || !i_slow);
    if (i_rst_n && i_valid && o_ready) begin
      q_ch.push_back(i_ch);
      q_data.push_back(i_data);
    end
  end
endmodule // ocl_sink

// >>> dv/ocl_testbench.sv
/* Self-checking bench for ocl_top: bypass, FIFO fill and drain, dynamics.
   Assumes ocl_defs.vh on the include path and ocl_sink as the far side. */
`timescale 1ns/1ps
`include "ocl_defs.vh"
module testbench;
  reg i_core_clk, i_rst_n, i_smp_valid, i_cfg_wr, i_out_gang, i_in_gang, stall, slow;
  reg [2:0] i_smp_ch, i_cfg_ch, i_rd_ch;
  reg signed [23:0] i_smp_data;
  reg [1:0] i_cfg_speed;
  reg [3:0] i_cfg_ratio;
  reg [15:0] i_cfg_thr;
  wire o_smp_ready, o_out_valid, i_out_ready, o_in_gang_active;
  wire [2:0] o_out_ch;
  wire signed [23:0] o_out_data;
  wire [15:0] o_rd_gain, o_rd_env;
  integer fail_count, samples_checked, k, n, r;
  reg [15:0] g[0:5];
  reg [2:0] gc;
  reg [23:0] gd;
  ocl_top i_ocl_top (.i_core_clk, .i_rst_n, .i_smp_valid, .o_smp_ready, .i_smp_ch,
    .i_smp_data, .o_out_valid, .i_out_ready, .o_out_ch, .o_out_data, .i_cfg_wr, .i_cfg_ch,
    .i_cfg_speed, .i_cfg_ratio, .i_cfg_thr, .i_out_gang, .i_in_gang, .o_in_gang_active,
    .i_rd_ch, .o_rd_gain, .o_rd_env);
  ocl_sink i_ocl_sink (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_stall(stall),
    .i_slow(slow), .i_valid(o_out_valid), .i_ch(o_out_ch), .i_data(o_out_data),
    .o_ready(i_out_ready));
  // Free-running core clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task results;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // A wait that runs out counts as a mismatch and ends the run
  task guard;
    begin
      if (n >= 300) begin
        fail_count = fail_count + 1;
        results;
      end
    end
  endtask
  task cfg(input [2:0] ch, input [1:0] sp, input [3:0] ra, input [15:0] th, input gang);
    begin
      @(posedge i_core_clk);
      i_cfg_wr <= 1'b1;
      i_cfg_ch <= ch;
      i_cfg_speed <= sp;
      i_cfg_ratio <= ra;
      i_cfg_thr <= th;
      i_out_gang <= gang;
      @(posedge i_core_clk);
      i_cfg_wr <= 1'b0;
    end
  endtask
  // Offer one sample and hold it until the FIFO takes it
  task send(input [2:0] ch, input [23:0] d);
    begin
      @(posedge i_core_clk);
      i_smp_valid <= 1'b1;
      i_smp_ch <= ch;
      i_smp_data <= d;
      n = 0;
      @(posedge i_core_clk);
      while (o_smp_ready !== 1'b1 && n < 300) begin
        n = n + 1;
        @(posedge i_core_clk);
      end
      guard;
      i_smp_valid <= 1'b0;
    end
  endtask
  task take;
    begin
      n = 0;
      while (i_ocl_sink.q_data.size() == 0 && n < 300) begin
        n = n + 1;
        @(posedge i_core_clk);
      end
      guard;
      gc = i_ocl_sink.q_ch.pop_front();
      gd = i_ocl_sink.q_data.pop_front();
    end
  endtask
  task rd(input [2:0] ch);
    begin
      @(posedge i_core_clk);
      i_rd_ch <= ch;
      repeat (2) @(posedge i_core_clk);
      #1;
    end
  endtask
  // Main sequence
  initial begin
    {fail_count, samples_checked} = 0;
    {i_rst_n, i_smp_valid, i_cfg_wr, i_out_gang, i_in_gang, stall, slow} = 7'h00;
    {i_smp_ch, i_cfg_ch, i_rd_ch, i_cfg_speed, i_cfg_ratio, i_cfg_thr} = 0;
    i_smp_data = 24'h00_0000;
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    i_in_gang <= 1'b1;
    rd(3'h0);
    check(o_rd_gain, `OCL_UNITY);
    rd(3'h6);
    check(o_rd_gain, 16'h0000);
    check(o_rd_env, 16'h0000);
    check(o_in_gang_active, 1'b1);
    $display("test reset done");
    // Fill with the converter stalled; the most negative value must pass intact
    stall <= 1'b1;
    @(posedge i_core_clk);
    i_smp_valid <= 1'b1;
    i_smp_data <= 24'h80_0000;
    k = 0;
    repeat (40) begin
      @(posedge i_core_clk);
      if (o_smp_ready === 1'b1) k = k + 1;
      i_smp_data <= 24'h80_0000 + k;
    end
    i_smp_valid <= 1'b0;
    check(k >= 16 && k <= 19, 1);
    stall <= 1'b0;
    slow <= 1'b1;
    for (r = 0; r < k; r = r + 1) begin
      take;
      check(gd, 24'h80_0000 + r);
    end
    check(i_ocl_sink.q_data.size(), 0);
    slow <= 1'b0;
    $display("test fill and drain done");
    // Below a high threshold the sample passes unchanged
    cfg(3'h1, `OCL_SPD_FAST, `OCL_RATIO_LIM, 16'h7000, 1'b0);
    send(3'h1, 24'hFF_F000);
    take;
    check(gd, 24'hFF_F000);
    check(gc, 3'h1);
    $display("test below threshold done");
    // Loud tone on every channel with different speeds, ratios and ganging
    cfg(3'h0, `OCL_SPD_FAST, `OCL_RATIO_LIM, 16'h1000, 1'b0);
    cfg(3'h1, `OCL_SPD_SLOW, `OCL_RATIO_LIM, 16'h1000, 1'b0);
    cfg(3'h2, `OCL_SPD_NORM, `OCL_RATIO_LIM, 16'h1000, 1'b1);
    cfg(3'h4, `OCL_SPD_FAST, 4'h1, 16'h1000, 1'b0);
    cfg(3'h5, `OCL_SPD_FAST, 4'hF, 16'h1000, 1'b0);
    repeat (40) begin
      for (r = 0; r < 6; r = r + 1) begin
        send(r[2:0], 24'h7F_0000);
        take;
        check(gc, r);
        if (r == 0) k = gd;
      end
    end
    for (r = 0; r < 6; r = r + 1) begin
      rd(r[2:0]);
      g[r] = o_rd_gain;
      if (r == 1) check(o_rd_env > 16'h1000 && o_rd_env <= 16'h7F00, 1);
    end
    check(g[0] < g[2], 1);
    check(g[2] < g[1], 1);
    check(g[1] < `OCL_UNITY, 1);
    check(g[3], g[2]);
    check(g[4] < g[5], 1);
    check(g[5] < `OCL_UNITY, 1);
    check(k < 24'h7F_0000, 1);
    check(k >= 24'h10_0000, 1);
    $display("test dynamics done");
    results;
  end
endmodule // testbench
